/* File: src/rsrc_cfg.svh */
// Constants of the reset and stop recovery controller
`ifndef RSRC_CFG_SVH
`define RSRC_CFG_SVH
`define RSRC_CLK_MHZ         100
`define RSRC_IPO_START_NS    4000
`define RSRC_IPO_START_CYC   ((`RSRC_IPO_START_NS * `RSRC_CLK_MHZ + 999) / 1000)
`define RSRC_HOLD_SHORT      66
`define RSRC_HOLD_LONG       5000
`define RSRC_PIN_MIN_CLKS    3
`define RSRC_STOP_FILT_CLKS  8
`define RSRC_VECTOR_HI_ADDR  16'h0002
`define RSRC_VECTOR_LO_ADDR  16'h0003
`define RSRC_OFS_CAUSE       12'hff0
`define RSRC_OFS_DBGCTL      12'hff4
`define RSRC_CAUSE_POR       7
`define RSRC_CAUSE_STOP      6
`define RSRC_CAUSE_WDOG      5
`define RSRC_CAUSE_EXT       4
`define RSRC_WDCTL_RESET     8'h00
`define RSRC_OSCILLATOR_CONTROL_REGISTER_RESET    8'ha0
`endif

/* File: src/rsrc_ctrl.sv */
// Reset and stop recovery sequencer with AXI4-Lite status port
// Functional notes
// RULE1: Reset on power, brownout, watchdog, pin, debugger
// RULE2: Debugger control bit 0 resets all but debugger
// RULE3: Stop mode recovers on watchdog or GPIO edge
// RULE4: Brownout input raises a reset
// RULE5: Hold core 66 oscillator cycles before release
// RULE6: Crystal option extends hold to 5000 cycles
// RULE7: Allow oscillator start-up before counting hold
// RULE8: Power resets count only after supply good
// RULE9: Stay in reset while pin held low
// RULE10: Reset makes GPIO inputs without pull-ups
// RULE11: Core and peripherals idle during reset
// RULE12: System reset loads defined register reset values
// RULE13: Core fetches vector at 0002h and 0003h
// RULE14: System reset selects internal oscillator clock
// RULE15: Stop recovery keeps registers except watchdog, oscillator
// RULE16: Ignore pin pulses under three clocks
// RULE17: Stop mode ignores pin pulses under filter
// RULE18: Debug pin low in stop resets system
// RULE19: Pin reset sets external cause bit
// RULE20: Stop watchdog sets watchdog and stop bits
// RULE21: Watchdog option zero gives interrupt instead
// RULE22: Drive reset pin low until delay ends
`timescale 1ns/1ps
`default_nettype none
`include "rsrc_cfg.svh"
module rsrc_ctrl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Analog and option inputs
    input  wire logic        por_detect,
    input  wire logic        brownout_detect,
    input  wire logic        supply_good,
    input  wire logic        xtal_option,
    input  wire logic        reset_on_watchdog_option,
    input  wire logic        ipo_tick,
    // Event inputs
    input  wire logic        stop_mode,
    input  wire logic        watchdog_timeout,
    input  wire logic        gpio_recovery,
    input  wire logic        debug_pin_in,
    // Reset pin, open drain
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    // Outputs to the chip
    output rsrc_pkg::rsrc_ctl_t ctl,
    output logic             watchdog_irq,
    output logic [15:0]      vector_addr,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // Sequencer state
    rsrc_pkg::rsrc_state_t state_r, state_nxt;
    logic [12:0] cnt_r, cnt_nxt;        // Start-up then hold counter
    logic        sys_r, sys_nxt;        // Current sequence is a system reset
    logic        pwr_r, pwr_nxt;        // Current reset came from supply
    logic [7:0]  cause_r, cause_nxt;    // Reset cause register
    logic        dbgctl_r, dbgctl_nxt;  // Debugger reset request bit
    logic        irq_r, irq_nxt;        // Watchdog interrupt pulse
    logic        pin_filt;              // Filtered pin level
    rsrc_pkg::rsrc_req_t req;           // Gathered sources
    logic        sys_req;               // Any system reset source
    logic        smr_req;               // Stop recovery source
    // Bus slave state, read by the sequencer
    logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt;
    logic [11:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  s_axi_wstrb_r, wstrb_nxt;
    logic        wr_fire;
    logic        rv_r, rv_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;

    // Pin filter, three clocks or analog-like window in stop
    rsrc_pin_filter u_pin (
        .clk_sys      (clk_sys),
        .rst_b        (rst_b),
        .pin_low      (!reset_pin_in && !reset_pin_oe), // Own drive is not a request
        .stop_mode    (stop_mode),
        .pin_asserted (pin_filt)
    );

    // Hold length in oscillator ticks
    function automatic logic [12:0] hold_len(input logic xt);
        hold_len = xt ? 13'(`RSRC_HOLD_LONG) : 13'(`RSRC_HOLD_SHORT); // RULE5 RULE6
    endfunction

    // Gather sources
    always_comb begin
        req.por     = por_detect; // RULE1
        req.bod     = brownout_detect; // RULE4
        req.wdog    = watchdog_timeout && reset_on_watchdog_option && !stop_mode; // RULE21
        req.pin     = pin_filt && state_r != rsrc_pkg::RSRC_PINWAIT; // RULE9
        req.dbg_ctl = dbgctl_r; // RULE2
        req.dbg_pin = stop_mode && !debug_pin_in; // RULE18
        sys_req     = |req;
        smr_req     = stop_mode && (watchdog_timeout || gpio_recovery); // RULE3
    end

    // Sequencer next state; a new system request restarts any sequence
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sys_nxt    = sys_r;
        pwr_nxt    = pwr_r;
        cause_nxt  = cause_r;
        dbgctl_nxt = dbgctl_r;
        irq_nxt    = watchdog_timeout && !reset_on_watchdog_option; // RULE21
        if (sys_req) begin
            state_nxt = (req.por || req.bod) ? rsrc_pkg::RSRC_SUPPLY : rsrc_pkg::RSRC_START;
            cnt_nxt   = 13'h0;
            sys_nxt   = 1'b1;
            pwr_nxt   = req.por || req.bod;
            cause_nxt = 8'h00;
            cause_nxt[`RSRC_CAUSE_POR] = req.por || req.bod || req.dbg_ctl || req.dbg_pin;
            cause_nxt[`RSRC_CAUSE_WDOG] = req.wdog;
            cause_nxt[`RSRC_CAUSE_EXT] = req.pin; // RULE19
            dbgctl_nxt = 1'b0; // Clears during reset
        end else if (smr_req && state_r == rsrc_pkg::RSRC_RUN) begin
            state_nxt = rsrc_pkg::RSRC_START;
            cnt_nxt   = 13'h0;
            sys_nxt   = 1'b0;
            pwr_nxt   = 1'b0;
            cause_nxt = 8'h00;
            cause_nxt[`RSRC_CAUSE_STOP] = 1'b1; // RULE20
            cause_nxt[`RSRC_CAUSE_WDOG] = watchdog_timeout; // RULE20
        end else begin
            unique case (state_r)
                rsrc_pkg::RSRC_IDLE: begin
                    state_nxt = rsrc_pkg::RSRC_START;
                end
                rsrc_pkg::RSRC_SUPPLY: begin
                    // Wait for supply above power-on level
                    if (supply_good) begin
                        state_nxt = rsrc_pkg::RSRC_START; // RULE8
                    end
                end
                rsrc_pkg::RSRC_START: begin
                    // Oscillator start-up time on the system clock
                    if (cnt_r >= 13'(`RSRC_IPO_START_CYC - 1)) begin
                        state_nxt = rsrc_pkg::RSRC_HOLD; // RULE7
                        cnt_nxt   = 13'h0;
                    end else begin
                        cnt_nxt = cnt_r + 13'h1;
                    end
                end
                rsrc_pkg::RSRC_HOLD: begin
                    // Count oscillator ticks
                    if (ipo_tick) begin
                        cnt_nxt = cnt_r + 13'h1;
                        if (cnt_nxt >= hold_len(xtal_option)) begin // RULE5 RULE6
                            state_nxt = rsrc_pkg::RSRC_PINWAIT;
                        end
                    end
                end
                rsrc_pkg::RSRC_PINWAIT: begin
                    // Stay while the pin is still low
                    if (reset_pin_in) begin
                        state_nxt = rsrc_pkg::RSRC_RUN; // RULE9
                    end
                end
                rsrc_pkg::RSRC_RUN: begin
                    state_nxt = rsrc_pkg::RSRC_RUN;
                end
            endcase
        end
        // Write of debugger control bit 0
        if (wr_fire && wr_addr_r == `RSRC_OFS_DBGCTL && s_axi_wstrb_r[0] && wdata_r[0]) begin
            dbgctl_nxt = 1'b1;
        end
    end

    // Sequencer registers; power-on state is a pending system reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= rsrc_pkg::RSRC_IDLE;
            cnt_r    <= 13'h0;
            sys_r    <= 1'b1;
            pwr_r    <= 1'b0;
            cause_r  <= 8'h80;
            dbgctl_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            sys_r    <= sys_nxt;
            pwr_r    <= pwr_nxt;
            cause_r  <= cause_nxt;
            dbgctl_r <= dbgctl_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // Chip controls derived from the sequence
    logic in_reset;
    always_comb begin
        in_reset       = state_r != rsrc_pkg::RSRC_RUN;
        ctl.core_rst   = in_reset; // RULE11
        ctl.periph_rst = in_reset; // RULE11
        ctl.regs_load  = in_reset && sys_r; // RULE12
        ctl.smr_load   = in_reset && !sys_r; // RULE15
        ctl.ipo_select = in_reset; // RULE14
        ctl.gpio_safe  = in_reset; // RULE10
        reset_pin_out  = 1'b0;
        reset_pin_oe   = in_reset && sys_r && state_r != rsrc_pkg::RSRC_PINWAIT; // RULE22
        watchdog_irq   = irq_r;
        vector_addr    = in_reset ? `RSRC_VECTOR_HI_ADDR : `RSRC_VECTOR_LO_ADDR; // RULE13
    end

    // AXI4-Lite slave: capture address and data in any order

    // Address decode of a word, unmapped gets SLVERR
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `RSRC_OFS_CAUSE) || (a == `RSRC_OFS_DBGCTL);
    endfunction

    always_comb begin
        aw_nxt      = aw_r;
        w_nxt       = w_r;
        b_nxt       = b_r;
        wr_addr_nxt = wr_addr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = s_axi_wstrb_r;
        bresp_nxt   = bresp_r;
        rv_nxt      = rv_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        s_axi_awready = !aw_r && !b_r;
        s_axi_wready  = !w_r && !b_r;
        s_axi_arready = !rv_r;
        wr_fire       = aw_r && w_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_nxt      = 1'b1;
            wr_addr_nxt = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_nxt     = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_nxt    = 1'b0;
            w_nxt     = 1'b0;
            b_nxt     = 1'b1;
            bresp_nxt = mapped(wr_addr_r) ? 2'b00 : 2'b10;
        end
        if (b_r && s_axi_bready) begin
            b_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt    = 1'b1;
            rresp_nxt = mapped({s_axi_araddr[11:2], 2'b00}) ? 2'b00 : 2'b10;
            if ({s_axi_araddr[11:2], 2'b00} == `RSRC_OFS_CAUSE) begin
                rdata_nxt = {24'h000000, cause_r};
            end else if ({s_axi_araddr[11:2], 2'b00} == `RSRC_OFS_DBGCTL) begin
                rdata_nxt = {31'h00000000, dbgctl_r};
            end else begin
                rdata_nxt = 32'h00000000;
            end
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            b_r <= 1'b0;
            wr_addr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            s_axi_wstrb_r <= 4'h0;
            bresp_r <= 2'b00;
            rv_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= 2'b00;
        end else begin
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            b_r <= b_nxt;
            wr_addr_r <= wr_addr_nxt;
            wdata_r <= wdata_nxt;
            s_axi_wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            rv_r <= rv_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_bvalid = b_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // Checks next to the sequencer
    a_sys_sources: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE1
        (por_detect || brownout_detect) |=> ctl.core_rst && ctl.regs_load)
        else $error("power source did not reset");
    a_dbg_bit: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE2
        dbgctl_r |=> ctl.core_rst && !dbgctl_r)
        else $error("debugger reset not taken");
    a_smr_start: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE3
        (state_r == rsrc_pkg::RSRC_RUN && smr_req && !sys_req) |=> ctl.smr_load && cause_r[`RSRC_CAUSE_STOP])
        else $error("stop recovery not started");
    a_supply_wait: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE8
        (state_r == rsrc_pkg::RSRC_SUPPLY && !supply_good && !sys_req) |=> state_r == rsrc_pkg::RSRC_SUPPLY)
        else $error("hold counted before supply good");
    a_pin_wait: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE9
        (state_r == rsrc_pkg::RSRC_PINWAIT && !reset_pin_in) |=> ctl.core_rst)
        else $error("released with pin low");
    a_short_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE5
        (state_r == rsrc_pkg::RSRC_HOLD && state_nxt == rsrc_pkg::RSRC_PINWAIT && !xtal_option)
        |-> cnt_nxt == 13'(`RSRC_HOLD_SHORT))
        else $error("hold length wrong");
    a_hold_count: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE6
        (state_r == rsrc_pkg::RSRC_HOLD && state_nxt == rsrc_pkg::RSRC_PINWAIT && !sys_req && xtal_option)
        |-> cnt_nxt == 13'(`RSRC_HOLD_LONG))
        else $error("hold ended at wrong count");
    a_ext_cause: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE19
        req.pin |=> cause_r[`RSRC_CAUSE_EXT])
        else $error("external cause not set");
    a_wdog_irq: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE21
        (watchdog_timeout && !reset_on_watchdog_option && !stop_mode && !sys_req) |=> !ctl.core_rst || $past(ctl.core_rst))
        else $error("watchdog reset while option zero");
    a_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE22
        sys_req |=> reset_pin_oe && !reset_pin_out)
        else $error("reset pin not driven low");
endmodule
`default_nettype wire

/* File: src/rsrc_pin_filter.sv */
// Low-pulse filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
`include "rsrc_cfg.svh"
module rsrc_pin_filter (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Pin and mode
    input  wire logic pin_low,
    input  wire logic stop_mode,
    // Filtered level
    output logic      pin_asserted
);
    logic [3:0] cnt_r;   // Consecutive low cycles
    logic [3:0] cnt_nxt;
    logic       pin_asserted_nxt;

    // Count low cycles; stop mode uses a longer window for the analog delay
    always_comb begin
        cnt_nxt = pin_low ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
        if (stop_mode) begin
            pin_asserted_nxt = cnt_nxt >= 4'(`RSRC_STOP_FILT_CLKS); // RULE17
        end else begin
            pin_asserted_nxt = cnt_nxt >= 4'(`RSRC_PIN_MIN_CLKS); // RULE16
        end
    end

    // Register count and level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r        <= 4'h0;
            pin_asserted <= 1'b0;
        end else begin
            cnt_r        <= cnt_nxt;
            pin_asserted <= pin_asserted_nxt;
        end
    end

    a_short_pulse_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE16
        (!stop_mode && cnt_r < 4'(`RSRC_PIN_MIN_CLKS) && !pin_low) |=> !pin_asserted)
        else $error("short reset pulse accepted");
endmodule
`default_nettype wire

/* File: src/rsrc_pkg.sv */
// Types of the reset and stop recovery controller
package rsrc_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        RSRC_IDLE, RSRC_SUPPLY, RSRC_START, RSRC_HOLD, RSRC_PINWAIT, RSRC_RUN
    } rsrc_state_t;
    // Reset request sources, sampled together
    typedef struct packed {
        logic por;
        logic bod;
        logic wdog;
        logic pin;
        logic dbg_ctl;
        logic dbg_pin;
    } rsrc_req_t;
    // Outputs toward the chip
    typedef struct packed {
        logic core_rst;
        logic periph_rst;
        logic regs_load;
        logic smr_load;
        logic ipo_select;
        logic gpio_safe;
    } rsrc_ctl_t;
endpackage

/* File: test/rsrc_far_model.sv */
// Far-side model: open-drain reset pin with pull-up and oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module rsrc_far_model #(
    parameter int IPO_DIV = 2 // Clocks per oscillator cycle
) (
    // Clock
    input  wire logic clk_sys,
    // External driver pulling the pin low
    input  wire logic ext_pull,
    // Device drive of the pin
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // Resolved pin level and oscillator
    output logic      pin_level,
    output logic      ipo_tick
);
    int div_r = 0; // Oscillator divider, free running

    // Any party pulling low wins; otherwise the pull-up holds the pin high
    assign pin_level = !(ext_pull || (pin_oe && !pin_out));
    // Tick once per oscillator cycle
    assign ipo_tick = (div_r == 0);

    // Oscillator keeps running through reset, so no reset here
    always_ff @(posedge clk_sys) begin
        div_r <= (div_r >= IPO_DIV - 1) ? 0 : div_r + 1;
    end
endmodule
`default_nettype wire

/* File: test/test_rsrc_ctrl.sv */
// Self-checking bench of the reset and stop recovery controller
`timescale 1ns/1ps
`default_nettype none
`include "rsrc_cfg.svh"
module test_rsrc_ctrl;
    localparam int IPO_DIV = 2; // Clocks per oscillator cycle
    logic                clk_sys, rst_b, por_detect, brownout_detect, supply_good, xtal_option;
    logic                reset_on_watchdog_option, stop_mode, watchdog_timeout, gpio_recovery;
    logic                debug_pin_in, ext_pull, ipo_tick, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic                watchdog_irq;
    rsrc_pkg::rsrc_ctl_t ctl;
    logic [15:0]         vector_addr;
    logic [11:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]         s_axi_wdata, s_axi_rdata, d;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp, r;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic                s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]          cause_mask [0:8] = '{8'h80, 8'h80, 8'h20, 8'h10, 8'h80, 8'h60, 8'h40, 8'h80, 8'h10};
    int                  failures = 0, n_compared = 0, cycles = 0, t0, n;

    rsrc_ctrl dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .por_detect(por_detect), .brownout_detect(brownout_detect),
        .supply_good(supply_good), .xtal_option(xtal_option), .ipo_tick(ipo_tick),
        .reset_on_watchdog_option(reset_on_watchdog_option), .stop_mode(stop_mode),
        .watchdog_timeout(watchdog_timeout), .gpio_recovery(gpio_recovery), .debug_pin_in(debug_pin_in),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .ctl(ctl), .watchdog_irq(watchdog_irq), .vector_addr(vector_addr),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    rsrc_far_model #(.IPO_DIV(IPO_DIV)) far (
        .clk_sys(clk_sys), .ext_pull(ext_pull), .pin_out(reset_pin_out), .pin_oe(reset_pin_oe),
        .pin_level(reset_pin_in), .ipo_tick(ipo_tick)
    );

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // Expected reset length in clocks: start-up plus IPO_DIV clocks per hold tick
    function automatic int hold_cyc(input logic x);
        return `RSRC_IPO_START_CYC + IPO_DIV * (x ? `RSRC_HOLD_LONG : `RSRC_HOLD_SHORT);
    endfunction
    // Write: address and data offered together, bready held until bvalid
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read: rready held until rvalid
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 100);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Wait for core reset to rise, bounded
    task automatic enter(input string nm);
        int k;
        k = 0;
        while (ctl.core_rst !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        chk(nm, ctl.core_rst, 1'b1);
    endtask
    // Outputs while the reset sequence runs
    task automatic sys_chk(input logic smr);
        cyc(1);
        chk("regs_load", ctl.regs_load, !smr);
        chk("smr_load", ctl.smr_load, smr);
        chk("gpio_safe", ctl.gpio_safe, 1'b1);
        chk("periph_rst", ctl.periph_rst, 1'b1);
        chk("ipo_select", ctl.ipo_select, 1'b1);
        chk("vector reset", vector_addr, 16'h0002);
        chk("pin drive", reset_pin_oe, !smr);
    endtask
    // Release time against the expected window, then run-state outputs
    task automatic check_rel(input string nm, input int ts, input logic x);
        int k;
        k = 0;
        while (ctl.core_rst !== 1'b0 && k < 12000) begin
            @(posedge clk_sys);
            k++;
        end
        chk(nm, (cycles - ts >= hold_cyc(x) - 2) && (cycles - ts <= hold_cyc(x) + 24), 1'b1);
        cyc(1);
        chk("vector run", vector_addr, 16'h0003);
        chk("pin release", reset_pin_oe, 1'b0);
    endtask
    // Fire one reset or recovery source; 5 and up happen in stop mode
    task automatic fire(input int k);
        if (k >= 5) stop_mode <= 1'b1;
        cyc(2);
        case (k)
            0: begin por_detect <= 1'b1; cyc(3); por_detect <= 1'b0; end
            1: begin brownout_detect <= 1'b1; cyc(3); brownout_detect <= 1'b0; end
            2, 5: begin watchdog_timeout <= 1'b1; cyc(1); watchdog_timeout <= 0; end
            3: begin ext_pull <= 1'b1; cyc(6); ext_pull <= 1'b0; end
            4: axi_wr(12'hff4, 32'h0000_0001, r);
            6: begin gpio_recovery <= 1'b1; cyc(1); gpio_recovery <= 1'b0; end
            7: begin debug_pin_in <= 1'b0; cyc(3); debug_pin_in <= 1'b1; end
            default: begin ext_pull <= 1'b1; cyc(12); ext_pull <= 1'b0; end
        endcase
    endtask

    // Main sequence
    initial begin
        {rst_b, por_detect, brownout_detect, xtal_option, stop_mode, watchdog_timeout} = '0;
        {gpio_recovery, ext_pull, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {supply_good, reset_on_watchdog_option, debug_pin_in} = 3'h7;
        s_axi_wstrb = 4'hf;
        cyc(20);
        rst_b <= 1'b1;
        t0 = cycles;
        sys_chk(1'b0);
        check_rel("boot release", t0, 1'b0);
        axi_rd(12'hffc, d, r);
        chk("unmapped rresp", r, 2'b10);
        chk("unmapped rdata", d, 32'h0);
        axi_wr(12'hff8, 32'h0000_00ff, r);
        chk("unmapped bresp", r, 2'b10);
        for (int k = 0; k < 9; k++) begin
            t0 = cycles;
            fire(k);
            enter("enter reset");
            stop_mode <= 1'b0;
            sys_chk(k == 5 || k == 6);
            check_rel("release", t0, 1'b0);
            axi_rd(12'hff0, d, r);
            chk("cause", d[7:0] & cause_mask[k], cause_mask[k]);
        end
        // Pulses below the filter length leave the core running
        ext_pull <= 1'b1;
        cyc(2);
        ext_pull <= 1'b0;
        cyc(30);
        chk("short pulse", ctl.core_rst, 1'b0);
        stop_mode <= 1'b1;
        ext_pull <= 1'b1;
        cyc(6);
        ext_pull <= 1'b0;
        cyc(30);
        chk("stop short pulse", ctl.core_rst, 1'b0);
        // Watchdog configured as interrupt
        stop_mode <= 1'b0;
        reset_on_watchdog_option <= 1'b0;
        cyc(2);
        watchdog_timeout <= 1'b1;
        cyc(1);
        watchdog_timeout <= 1'b0;
        n = 0;
        while (watchdog_irq !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        chk("watchdog irq", watchdog_irq, 1'b1);
        cyc(20);
        chk("no watchdog reset", ctl.core_rst, 1'b0);
        reset_on_watchdog_option <= 1'b1;
        // Power reset waits for supply good before counting
        supply_good <= 1'b0;
        por_detect <= 1'b1;
        cyc(3);
        por_detect <= 1'b0;
        cyc(1000);
        chk("supply wait", ctl.core_rst, 1'b1);
        supply_good <= 1'b1;
        t0 = cycles;
        check_rel("supply release", t0, 1'b0);
        // Pin held beyond the hold count
        ext_pull <= 1'b1;
        cyc(hold_cyc(1'b0) + 200);
        chk("pin held", ctl.core_rst, 1'b1);
        ext_pull <= 1'b0;
        n = 0;
        while (ctl.core_rst !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("pin release", n <= 4, 1'b1);
        // Crystal option lengthens the hold
        xtal_option <= 1'b1;
        t0 = cycles;
        fire(0);
        enter("xtal enter");
        check_rel("xtal release", t0, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
